// [hw/mucr_cfg.svh]
`ifndef MUCR_CFG_SVH
`define MUCR_CFG_SVH

// register addresses on the processor bus
`define MUCR_ADDR_MAIN_CONFIG   16'hD380
`define MUCR_ADDR_AUX_CONFIG    16'hD381
`define MUCR_ADDR_EXP_CART_CFG  16'hD382
`define MUCR_ADDR_COLD_FLAG     16'hD383
`define MUCR_ADDR_BUTTON_STAT   16'hD384
`define MUCR_ADDR_CLOCK_PORT    16'hD3E2
`define MUCR_ADDR_CART_CTRL     16'hD5E0
`define MUCR_ADDR_BANKING_PORT  16'hD301

// field positions
`define MUCR_MAIN_LOCK_BIT      7
`define MUCR_MAIN_DOS_OFF_BIT   4
`define MUCR_AUX_FLASH_WP_BIT   7
`define MUCR_AUX_SOUND_BIT      6
`define MUCR_EXP_BUTTON_BIT     3
`define MUCR_EXP_EMUL_BIT       2
`define MUCR_COLD_FLAG_BIT      7
`define MUCR_STAT_BUTTON_BIT    5
`define MUCR_STAT_UPPER_BIT     6
`define MUCR_CLK_SDI_BIT        3
`define MUCR_CLK_SDO_BIT        2
`define MUCR_CLK_SCLK_BIT       1
`define MUCR_CLK_CE_BIT         0

// reset values
`define MUCR_MAIN_RESET         8'h00
`define MUCR_AUX_RESET          8'h00
`define MUCR_EXP_RESET          8'h00
`define MUCR_CART_FORCED        8'h80
`define MUCR_BANKING_RESET      8'hFF

// flash region bases and video add-on bases
`define MUCR_OS_ROM_BASE        19'h70000
`define MUCR_GAME_ROM_BASE      19'h68000
`define MUCR_LANG_ROM_BASE      19'h60000
`define MUCR_VIDEO_BASE_LO      16'hD640
`define MUCR_VIDEO_BASE_HI      16'hD740

`endif

// [hw/mucr_pkg.sv]
package mucr_pkg;

  // extended memory scheme, as held in the main config low field
  typedef enum logic [1:0] {
    MUCR_MEM_64K   = 2'h0,
    MUCR_MEM_320K  = 2'h1,
    MUCR_MEM_576K  = 2'h2,
    MUCR_MEM_1088K = 2'h3
  } mucr_mem_e;

  typedef logic [7:0] mucr_byte_t;

endpackage : mucr_pkg

// [hw/mucr_bank_decode.sv]
`timescale 1ns/1ps

// pure decode of the shadowed banking port into bank and access enables
module mucr_bank_decode (
  input  wire logic [1:0] mem_mode,
  input  wire logic [7:0] banking_port,
  output logic      [5:0] bank,
  output logic            cpu_window_en,
  output logic            video_window_en
);

  // window enables are active low on the port, as on the stock machine
  always_comb begin
    bank            = 6'h00;
    cpu_window_en   = 1'b0;
    video_window_en = 1'b0;
    case (mucr_pkg::mucr_mem_e'(mem_mode))
      mucr_pkg::MUCR_MEM_64K: begin
        bank = 6'h00;
      end
      mucr_pkg::MUCR_MEM_320K: begin
        bank            = {2'h0, banking_port[6:5], banking_port[3:2]};
        cpu_window_en   = ~banking_port[4];
        video_window_en = ~banking_port[4];
      end
      mucr_pkg::MUCR_MEM_576K: begin
        bank            = {1'h0, banking_port[7:6], banking_port[3:1]};
        cpu_window_en   = ~banking_port[4];
        video_window_en = ~banking_port[5];
      end
      mucr_pkg::MUCR_MEM_1088K: begin
        bank            = {banking_port[7:5], banking_port[3:1]};
        cpu_window_en   = ~banking_port[4];
        video_window_en = ~banking_port[4];
      end
      default: begin
        bank = 6'h00;
      end
    endcase
  end

endmodule : mucr_bank_decode

// [hw/mucr_config_regs.sv]
`timescale 1ns/1ps
`include "mucr_cfg.svh"

// How it works
// - two-bit memory field picks none, 320K, 576K or 1088K banking
// - 576K bank from port bits 1,2,3,6,7; bit4 cpu, bit5 video
// - 320K bits 2,3,5,6; 1088K bits 1,2,3,5,6,7; bit4 gates both
// - auxiliary and cartridge config writable only unlocked, never readable
// - write protect bit 0 lets flash writes through, 1 blocks them
// - sound bit gives 0xD210-0xD2FF to add-on at 1, original chip at 0
// - video field: 00 at 0xD640, 01 at 0xD740, upper bit set disables
// - low four auxiliary bits drive the four decode signal outputs
// - emulation enable bit turns expansion bus emulation off or on
// - device select picks number 0,2,4,6 with masks 01,04,10,40
// - cold flag set at power-up, software writable, kept across warm reset
// - once locked, cold flag ignores writes but stays readable
// - status bit 5 reports button feature, bit 6 upper window sense
// - clock port read returns serial data input on bit 3
// - clock port write drives data out bit2, clock bit1, select bit0
// - cartridge field 0x internal, 10 external, 11 none; low six bits bank
// - external windows enabled together; button feature kills upper one
// - cartridge control held at 0x80 while the dos module is off
// - cartridge control writes still reach the external cartridge region
// - lock cannot be cleared by software, only by reset
module mucr_config_regs (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        warm_reset,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic        upper_window_sense,
  input  wire logic        clock_sdi,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_rdata_drive,
  output logic             cart_region_pass,
  output logic             config_locked,
  output logic      [5:0]  ext_bank,
  output logic             cpu_window_en,
  output logic             video_window_en,
  output logic      [18:0] os_rom_base,
  output logic      [18:0] game_rom_base,
  output logic      [18:0] lang_rom_base,
  output logic             flash_write_en,
  output logic             sound_addon_select,
  output logic      [15:0] video_addon_base,
  output logic             video_addon_en,
  output logic      [3:0]  decode_signal_outputs,
  output logic             expansion_bus_emulation,
  output logic      [7:0]  emulated_device_mask,
  output logic             button_feature_enable,
  output logic             cold_flag_bit,
  output logic             clock_sdo,
  output logic             clock_sclk,
  output logic             clock_ce,
  output logic             int_cart_en,
  output logic             ext_cart_lower_en,
  output logic             ext_cart_upper_en,
  output logic      [5:0]  internal_cartridge_bank
);

  // register state
  logic [7:0] main_q, main_d;
  logic [7:0] aux_q, aux_d;
  logic [7:0] exp_q, exp_d;
  logic       cold_q, cold_d;
  logic [7:0] bank_port_q, bank_port_d;
  logic [2:0] clk_port_q, clk_port_d;
  logic [7:0] cart_q, cart_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rdrive_q, rdrive_d;
  logic       pass_q, pass_d;

  // decoded outputs, registered below so each banking port comes from a flop
  logic [5:0]  bank_c;
  logic        cpu_win_c;
  logic        vid_win_c;
  logic [5:0]  ext_bank_q;
  logic        cpu_win_q;
  logic        vid_win_q;

  logic        unlocked;
  logic        dos_off;
  logic        hit_main;
  logic        hit_aux;
  logic        hit_exp;
  logic        hit_cold;
  logic        hit_stat;
  logic        hit_clk;
  logic        hit_cart;
  logic        hit_bank;

  assign unlocked = ~main_q[`MUCR_MAIN_LOCK_BIT];
  assign dos_off  = main_q[`MUCR_MAIN_DOS_OFF_BIT];
  assign hit_main = (cpu_addr == `MUCR_ADDR_MAIN_CONFIG);
  assign hit_aux  = (cpu_addr == `MUCR_ADDR_AUX_CONFIG);
  assign hit_exp  = (cpu_addr == `MUCR_ADDR_EXP_CART_CFG);
  assign hit_cold = (cpu_addr == `MUCR_ADDR_COLD_FLAG);
  assign hit_stat = (cpu_addr == `MUCR_ADDR_BUTTON_STAT);
  assign hit_clk  = (cpu_addr == `MUCR_ADDR_CLOCK_PORT);
  assign hit_cart = (cpu_addr == `MUCR_ADDR_CART_CTRL);
  assign hit_bank = (cpu_addr == `MUCR_ADDR_BANKING_PORT);

  // banking scheme decode lives in its own leaf
  mucr_bank_decode u_bank_decode (
    .mem_mode        (main_q[1:0]),
    .banking_port    (bank_port_q),
    .bank            (bank_c),
    .cpu_window_en   (cpu_win_c),
    .video_window_en (vid_win_c)
  );

  // next state of the configuration registers
  always_comb begin
    main_d      = main_q;
    aux_d       = aux_q;
    exp_d       = exp_q;
    cold_d      = cold_q;
    bank_port_d = bank_port_q;
    clk_port_d  = clk_port_q;
    cart_d      = cart_q;
    if (cpu_wr && hit_main && unlocked) begin
      main_d = cpu_wdata;                       // lock bit can only go 0 -> 1 here
    end
    if (cpu_wr && hit_aux && unlocked) begin
      aux_d = cpu_wdata;
    end
    if (cpu_wr && hit_exp && unlocked) begin
      exp_d = cpu_wdata;
    end
    if (cpu_wr && hit_cold && unlocked) begin
      cold_d = cpu_wdata[`MUCR_COLD_FLAG_BIT];
    end
    // shadow of the port; the real port still sees the write
    if (cpu_wr && hit_bank) begin
      bank_port_d = cpu_wdata;
    end
    // one store sets all three lines at once; pacing is software's job
    if (cpu_wr && hit_clk) begin
      clk_port_d = cpu_wdata[2:0];
    end
    // gated on the dos module, not on the register itself, so a reset value of 0x80 can't lock it
    if (cpu_wr && hit_cart && !dos_off) begin
      cart_d = cpu_wdata;
    end
    if (dos_off) begin
      cart_d = `MUCR_CART_FORCED;
    end
    // a warm reset unlocks and resets config but keeps the cold flag
    if (warm_reset) begin
      main_d      = `MUCR_MAIN_RESET;
      aux_d       = `MUCR_AUX_RESET;
      exp_d       = `MUCR_EXP_RESET;
      bank_port_d = `MUCR_BANKING_RESET;
      clk_port_d  = 3'h0;
      cart_d      = `MUCR_CART_FORCED;
      cold_d      = cold_q;
    end
  end

  // read path: write-only locations leave the bus undriven
  always_comb begin
    rdata_d  = 8'h00;
    rdrive_d = 1'b0;
    pass_d   = 1'b0;
    if (cpu_rd) begin
      if (hit_cold) begin
        rdata_d  = {cold_q, 7'h00};             // readable locked or not
        rdrive_d = 1'b1;
      end else if (hit_stat) begin
        rdata_d[`MUCR_STAT_BUTTON_BIT] = exp_q[`MUCR_EXP_BUTTON_BIT];
        rdata_d[`MUCR_STAT_UPPER_BIT]  = upper_window_sense;
        rdrive_d = 1'b1;
      end else if (hit_clk) begin
        rdata_d[`MUCR_CLK_SDI_BIT] = clock_sdi;
        rdrive_d = 1'b1;
      end
    end
    // aux and cartridge config are never read back
    // cartridge control store is also passed on to the cartridge region
    if (cpu_wr && hit_cart) begin
      pass_d = 1'b1;
    end
  end

  // power-on reset only here; warm reset is handled in the next-state logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_q      <= `MUCR_MAIN_RESET;
      aux_q       <= `MUCR_AUX_RESET;
      exp_q       <= `MUCR_EXP_RESET;
      cold_q      <= 1'b1;
      bank_port_q <= `MUCR_BANKING_RESET;
      clk_port_q  <= 3'h0;
      cart_q      <= `MUCR_CART_FORCED;
      rdata_q     <= 8'h00;
      rdrive_q    <= 1'b0;
      pass_q      <= 1'b0;
      ext_bank_q  <= 6'h00;
      cpu_win_q   <= 1'b0;
      vid_win_q   <= 1'b0;
    end else begin
      main_q      <= main_d;
      aux_q       <= aux_d;
      exp_q       <= exp_d;
      cold_q      <= cold_d;
      bank_port_q <= bank_port_d;
      clk_port_q  <= clk_port_d;
      cart_q      <= cart_d;
      rdata_q     <= rdata_d;
      rdrive_q    <= rdrive_d;
      pass_q      <= pass_d;
      ext_bank_q  <= bank_c;
      cpu_win_q   <= cpu_win_c;
      vid_win_q   <= vid_win_c;
    end
  end

  // bus answer and banking outputs
  assign cpu_rdata        = rdata_q;
  assign cpu_rdata_drive  = rdrive_q;
  assign cart_region_pass = pass_q;
  assign config_locked    = main_q[`MUCR_MAIN_LOCK_BIT];
  assign ext_bank         = ext_bank_q;
  assign cpu_window_en    = cpu_win_q;
  assign video_window_en  = vid_win_q;

  // flash region bases, each a slice of a register
  assign os_rom_base   = `MUCR_OS_ROM_BASE   + {3'h0, main_q[3:2], 14'h0000};
  assign game_rom_base = `MUCR_GAME_ROM_BASE + {4'h0, exp_q[7:6], 13'h0000};
  assign lang_rom_base = `MUCR_LANG_ROM_BASE + {4'h0, exp_q[5:4], 13'h0000};

  // auxiliary decode controls
  assign flash_write_en        = ~aux_q[`MUCR_AUX_FLASH_WP_BIT];
  assign sound_addon_select    = aux_q[`MUCR_AUX_SOUND_BIT];
  assign video_addon_base      = aux_q[4] ? `MUCR_VIDEO_BASE_HI
                                          : `MUCR_VIDEO_BASE_LO;
  assign video_addon_en        = ~aux_q[5];
  assign decode_signal_outputs = aux_q[3:0];

  // expansion bus emulation; mask is zero while emulation is off
  assign expansion_bus_emulation = exp_q[`MUCR_EXP_EMUL_BIT];
  assign emulated_device_mask    = exp_q[`MUCR_EXP_EMUL_BIT] ?
                                   (8'h01 << {exp_q[1:0], 1'b0}) : 8'h00;
  assign button_feature_enable   = exp_q[`MUCR_EXP_BUTTON_BIT];
  assign cold_flag_bit           = cold_q;

  // serial clock chip lines come straight from the port flops
  assign clock_sdo  = clk_port_q[`MUCR_CLK_SDO_BIT];
  assign clock_sclk = clk_port_q[`MUCR_CLK_SCLK_BIT];
  assign clock_ce   = clk_port_q[`MUCR_CLK_CE_BIT];    // 1 selects the chip

  // cartridge enables; button feature hides only the upper window
  assign int_cart_en             = ~cart_q[7];
  assign ext_cart_lower_en       = (cart_q[7:6] == 2'h2);
  assign ext_cart_upper_en       = (cart_q[7:6] == 2'h2) &&
                                   !exp_q[`MUCR_EXP_BUTTON_BIT];
  assign internal_cartridge_bank = cart_q[5:0];

endmodule : mucr_config_regs

// [verif/mucr_cfg_monitor.sv]
`timescale 1ns/1ps
`include "mucr_cfg.svh"

// bus-to-port relations of the config block
module mucr_cfg_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        warm_reset,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic        clock_sdi,
  input wire logic [7:0]  cpu_rdata,
  input wire logic        cpu_rdata_drive,
  input wire logic        cart_region_pass,
  input wire logic        config_locked,
  input wire logic        cold_flag_bit,
  input wire logic        clock_sdo,
  input wire logic        clock_sclk,
  input wire logic        clock_ce,
  input wire logic        button_feature_enable,
  input wire logic        ext_cart_upper_en,
  input wire logic        flash_write_en
);
  // one domain, so clock and disable given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_CART_PASS: assert property (cpu_wr && cpu_addr == `MUCR_ADDR_CART_CTRL
    |=> cart_region_pass) else $error("cart write not passed on");
  AST_CLK_READ: assert property (cpu_rd && cpu_addr == `MUCR_ADDR_CLOCK_PORT |=>
    cpu_rdata_drive && cpu_rdata[3] == $past(clock_sdi)) else $error("clock port read wrong");
  AST_CLK_WRITE: assert property (cpu_wr && !warm_reset &&
    cpu_addr == `MUCR_ADDR_CLOCK_PORT |=>
    {clock_sdo, clock_sclk, clock_ce} == $past(cpu_wdata[2:0])) else $error("clock lines wrong");
  AST_AUX_HIDDEN: assert property (cpu_rd && cpu_addr == `MUCR_ADDR_AUX_CONFIG
    |=> !cpu_rdata_drive) else $error("aux register readable");
  AST_LOCK_STICKY: assert property (config_locked && !warm_reset |=> config_locked)
    else $error("lock cleared");
  AST_COLD_LOCKED: assert property (config_locked |=> $stable(cold_flag_bit))
    else $error("cold flag changed while locked");
  AST_COLD_WARM: assert property (warm_reset && !cpu_wr |=> $stable(cold_flag_bit))
    else $error("cold flag lost on warm reset");
  AST_UPPER_BTN: assert property (button_feature_enable |-> !ext_cart_upper_en)
    else $error("upper window on with button");
  AST_FLASH_WP: assert property (cpu_wr && !config_locked && !warm_reset &&
    cpu_addr == `MUCR_ADDR_AUX_CONFIG |=> flash_write_en == !$past(cpu_wdata[7]))
    else $error("flash write enable wrong");
endmodule : mucr_cfg_monitor

bind mucr_config_regs mucr_cfg_monitor i_mon (
  .clk                   (clk),
  .resetn                (resetn),
  .warm_reset            (warm_reset),
  .cpu_addr              (cpu_addr),
  .cpu_wdata             (cpu_wdata),
  .cpu_wr                (cpu_wr),
  .cpu_rd                (cpu_rd),
  .clock_sdi             (clock_sdi),
  .cpu_rdata             (cpu_rdata),
  .cpu_rdata_drive       (cpu_rdata_drive),
  .cart_region_pass      (cart_region_pass),
  .config_locked         (config_locked),
  .cold_flag_bit         (cold_flag_bit),
  .clock_sdo             (clock_sdo),
  .clock_sclk            (clock_sclk),
  .clock_ce              (clock_ce),
  .button_feature_enable (button_feature_enable),
  .ext_cart_upper_en     (ext_cart_upper_en),
  .flash_write_en        (flash_write_en)
);

// [verif/mucr_clock_chip.sv]
`timescale 1ns/1ps

// serial clock chip: shifts in on rising clock, msb out
module mucr_clock_chip #(
  parameter logic [7:0] INIT = 8'hA5
) (
  input  wire logic ce,
  input  wire logic sclk,
  input  wire logic sdo,
  output logic      sdi
);
  logic [7:0] sr_q = INIT;
  logic       last_q = 1'b0;

  // shifting only while selected
  always @(posedge sclk) if (ce) sr_q <= {sr_q[6:0], sdo};
  // released line shows the inverse, not a stale bit
  always @(negedge ce) last_q <= sr_q[7];
  assign sdi = ce ? sr_q[7] : ~last_q;
endmodule : mucr_clock_chip

// [verif/mucr_config_regs_tb_top.sv]
`timescale 1ns/1ps
`include "mucr_cfg.svh"

module mucr_config_regs_tb_top;
  logic clk = 1'b0;
  logic resetn, warm_reset, cpu_wr, cpu_rd, upper_window_sense, clock_sdi, drv;
  logic [15:0] cpu_addr, video_addon_base;
  logic [7:0]  cpu_wdata, cpu_rdata, emulated_device_mask, d, e;
  logic [18:0] os_rom_base, game_rom_base, lang_rom_base;
  logic [5:0]  ext_bank, internal_cartridge_bank;
  logic [3:0]  decode_signal_outputs;
  logic cpu_rdata_drive, cart_region_pass, config_locked, cpu_window_en, video_window_en;
  logic flash_write_en, sound_addon_select, video_addon_en, expansion_bus_emulation;
  logic button_feature_enable, cold_flag_bit, clock_sdo, clock_sclk, clock_ce;
  logic int_cart_en, ext_cart_lower_en, ext_cart_upper_en;
  int n_mismatch = 0;
  int cmp_count = 0;
  // banking port per scheme and expected {bank, cpu, video}
  logic [7:0] port_v [4] = '{8'h00, 8'h64, 8'h22, 8'hCA};
  logic [7:0] bank_v [4] = '{8'h00, 8'h37, 8'h06, 8'hD7};

  mucr_config_regs i_dut (
    .clk                     (clk),
    .resetn                  (resetn),
    .warm_reset              (warm_reset),
    .cpu_addr                (cpu_addr),
    .cpu_wdata               (cpu_wdata),
    .cpu_wr                  (cpu_wr),
    .cpu_rd                  (cpu_rd),
    .upper_window_sense      (upper_window_sense),
    .clock_sdi               (clock_sdi),
    .cpu_rdata               (cpu_rdata),
    .cpu_rdata_drive         (cpu_rdata_drive),
    .cart_region_pass        (cart_region_pass),
    .config_locked           (config_locked),
    .ext_bank                (ext_bank),
    .cpu_window_en           (cpu_window_en),
    .video_window_en         (video_window_en),
    .os_rom_base             (os_rom_base),
    .game_rom_base           (game_rom_base),
    .lang_rom_base           (lang_rom_base),
    .flash_write_en          (flash_write_en),
    .sound_addon_select      (sound_addon_select),
    .video_addon_base        (video_addon_base),
    .video_addon_en          (video_addon_en),
    .decode_signal_outputs   (decode_signal_outputs),
    .expansion_bus_emulation (expansion_bus_emulation),
    .emulated_device_mask    (emulated_device_mask),
    .button_feature_enable   (button_feature_enable),
    .cold_flag_bit           (cold_flag_bit),
    .clock_sdo               (clock_sdo),
    .clock_sclk              (clock_sclk),
    .clock_ce                (clock_ce),
    .int_cart_en             (int_cart_en),
    .ext_cart_lower_en       (ext_cart_lower_en),
    .ext_cart_upper_en       (ext_cart_upper_en),
    .internal_cartridge_bank (internal_cartridge_bank)
  );
  mucr_clock_chip i_chip (.ce(clock_ce), .sclk(clock_sclk), .sdo(clock_sdo), .sdi(clock_sdi));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // strobe held one edge, then a free cycle so strobes never touch
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    v = cpu_rdata;
    drv = cpu_rdata_drive;
    @(negedge clk);
  endtask : rd

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk

  // clock rises alone; it falls in the same store that sets the next data bit
  task automatic xfer(input logic [7:0] o, output logic [7:0] r);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      wr(`MUCR_ADDR_CLOCK_PORT, {5'h00, o[i], 2'b01});
      rd(`MUCR_ADDR_CLOCK_PORT, v);
      r[i] = v[3];
      wr(`MUCR_ADDR_CLOCK_PORT, {5'h00, o[i], 2'b11});
      idle(1); // keeps a full three cycles before the clock falls again
    end
    wr(`MUCR_ADDR_CLOCK_PORT, 8'h01);
  endtask : xfer

  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    {resetn, warm_reset, cpu_wr, cpu_rd, upper_window_sense} = 5'h00;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    idle(6);
    resetn = 1'b1;
    idle(1);
    rd(`MUCR_ADDR_COLD_FLAG, d);
    chk({drv, d[7]}, 2'b11);
    chk({int_cart_en, ext_cart_lower_en, ext_cart_upper_en}, 3'b011);
    wr(`MUCR_ADDR_CART_CTRL, 8'h05);
    chk({int_cart_en, internal_cartridge_bank}, 7'h45);
    wr(`MUCR_ADDR_CART_CTRL, 8'hC0);
    chk({int_cart_en, ext_cart_lower_en, ext_cart_upper_en}, 3'b000);
    for (int i = 0; i < 4; i++) begin
      wr(`MUCR_ADDR_MAIN_CONFIG, {4'h0, i[1:0], i[1:0]});
      wr(`MUCR_ADDR_BANKING_PORT, port_v[i]);
      chk({ext_bank, cpu_window_en, video_window_en}, bank_v[i]);
      chk(os_rom_base, 19'h70000 + 19'h04000 * i);
      e = {4{i[1:0]}};
      wr(`MUCR_ADDR_AUX_CONFIG, e);
      chk({flash_write_en, sound_addon_select}, {!e[7], e[6]});
      chk(video_addon_en, !e[5]);
      if (!e[5]) chk(video_addon_base, e[4] ? 16'hD740 : 16'hD640);
      chk(decode_signal_outputs, e[3:0]);
      wr(`MUCR_ADDR_EXP_CART_CFG, {i[1:0], i[1:0], 2'b01, i[1:0]});
      chk({expansion_bus_emulation, emulated_device_mask}, {1'b1, 8'h01 << (2 * i)});
      chk(game_rom_base, 19'h68000 + 19'h02000 * i);
      chk(lang_rom_base, 19'h60000 + 19'h02000 * i);
    end
    rd(`MUCR_ADDR_EXP_CART_CFG, d);
    chk(drv, 1'b0);
    wr(`MUCR_ADDR_CART_CTRL, 8'h80);
    wr(`MUCR_ADDR_EXP_CART_CFG, 8'h08);
    chk({expansion_bus_emulation, emulated_device_mask}, 9'h000);
    chk({ext_cart_lower_en, ext_cart_upper_en}, 2'b10);
    upper_window_sense = 1'b1;
    rd(`MUCR_ADDR_BUTTON_STAT, d);
    chk(d[6:5], 2'b11);
    upper_window_sense = 1'b0;
    wr(`MUCR_ADDR_COLD_FLAG, 8'h00);
    rd(`MUCR_ADDR_COLD_FLAG, d);
    chk(d[7], 1'b0);
    warm_reset = 1'b1;
    idle(1);
    warm_reset = 1'b0;
    rd(`MUCR_ADDR_COLD_FLAG, d);
    chk({d[7], button_feature_enable}, 2'b00);
    wr(`MUCR_ADDR_COLD_FLAG, 8'h80);
    wr(`MUCR_ADDR_CART_CTRL, 8'h07);
    chk(int_cart_en, 1'b1);
    wr(`MUCR_ADDR_MAIN_CONFIG, 8'h90);
    chk({config_locked, int_cart_en, ext_cart_lower_en}, 3'b101);
    wr(`MUCR_ADDR_COLD_FLAG, 8'h00);
    rd(`MUCR_ADDR_COLD_FLAG, d);
    chk(d[7], 1'b1);
    wr(`MUCR_ADDR_MAIN_CONFIG, 8'h00);
    wr(`MUCR_ADDR_AUX_CONFIG, 8'h80);
    chk({config_locked, flash_write_en}, 2'b11);
    wr(`MUCR_ADDR_CLOCK_PORT, 8'h01);
    idle(7);
    xfer(8'h3C, d);
    chk(d, 8'hA5);
    wr(`MUCR_ADDR_CLOCK_PORT, 8'h00);
    idle(7);
    wr(`MUCR_ADDR_CLOCK_PORT, 8'h01);
    idle(7);
    xfer(8'h00, d);
    chk(d, 8'h3C);
    finish_test();
  end
endmodule : mucr_config_regs_tb_top
